// ### design/eppc_pkg.sv
// Package for the nonvolatile array program and protect controller.
// Assumes a 32-bit Avalon-MM slave with byte offsets as given here.
package eppc_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [11:0] ARRAY_BASE_ADDR   = 12'h000;
   localparam logic [11:0] ARRAY_END_ADDR    = 12'h7FC;
   localparam logic [11:0] PROG_CTRL_ADDR    = 12'h800;
   localparam logic [11:0] BLOCK_PROT_ADDR   = 12'h804;
   localparam logic [11:0] SYS_OPTION_ADDR   = 12'h808;
   localparam logic [11:0] SETUP_REG_ADDR    = 12'h80C;
   localparam logic [11:0] OTP_CTRL_ADDR     = 12'h810;
   localparam logic [11:0] STATUS_ADDR       = 12'h814;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int PC_PUMP_BIT    = 0;
   localparam int PC_ERASE_BIT   = 2;
   localparam int PC_LATCH_BIT   = 1;
   localparam int OTP_VOLT_BIT   = 0;
   localparam int OTP_LATCH_BIT  = 5;
   localparam int OPT_PUMP_CLOCK_SELECT_BIT   = 6;
   localparam int SETUP_VIS_BIT  = 0;
   localparam int PROT_BITS      = 4;
   // ------------------------------------------------------------
   // Reset values and sizes
   // ------------------------------------------------------------
   localparam logic [3:0] PROT_RESET    = 4'h_F;
   localparam logic [7:0] SETUP_RESET   = 8'h_FF;
   localparam logic [7:0] ERASED_BYTE   = 8'h_FF;
   localparam int         ARRAY_BYTES   = 512;
   localparam int         PROT_WINDOW_CYCLES = 64;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      EPPC_MODE_SINGLE,
      EPPC_MODE_EXPANDED,
      EPPC_MODE_BOOT,
      EPPC_MODE_TEST
   } eppc_mode_t;
   typedef enum {EPPC_IDLE, EPPC_ARMED, EPPC_TARGET, EPPC_PUMPING} eppc_seq_t;
endpackage : eppc_pkg

// ### design/eppc_store.sv
// Nonvolatile byte store with erase-to-ones and program-to-zero behaviour.
// Assumes the controller only strobes program or erase after arming.
`timescale 1ns/1ps
`default_nettype none
module eppc_store #(
   parameter int DEPTH = eppc_pkg::ARRAY_BYTES
) (
   // Clock and reset
   input  wire logic                     clk_in,
   input  wire logic                     rst_n_in,
   // Access
   input  wire logic [$clog2(DEPTH)-1:0] idx_in,
   input  wire logic                     prog_in,
   input  wire logic                     erase_in,
   input  wire logic [7:0]               data_in,
   output logic      [7:0]               data_out
);
   logic [7:0] mem_q [DEPTH];
   assign data_out = mem_q[idx_in];
   // Erase sets every bit high; programming only pulls bits low.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < DEPTH; i++) mem_q[i] <= eppc_pkg::ERASED_BYTE;
      end else if (erase_in) begin
         mem_q[idx_in] <= eppc_pkg::ERASED_BYTE;
      end else if (prog_in) begin
         mem_q[idx_in] <= mem_q[idx_in] & data_in;
      end
   end
endmodule : eppc_store
`default_nettype wire

// ### design/eppc_ctrl.sv
// Program and protect controller for a byte-wide nonvolatile array.
// Assumes an Avalon-MM master on CLK_IN and a mode value steady after reset.
`timescale 1ns/1ps
`default_nettype none
module eppc_ctrl #(
   parameter int DEPTH = eppc_pkg::ARRAY_BYTES,
   parameter int PROT_WINDOW = eppc_pkg::PROT_WINDOW_CYCLES
) (
   // Clock and reset
   input  wire logic        CLK_IN,
   input  wire logic        RST_N_IN,
   // Operating mode
   input  wire logic [1:0]  MODE_IN,
   // Avalon-MM slave
   input  wire logic [11:0] AVS_ADDRESS_IN,
   input  wire logic        AVS_READ_IN,
   input  wire logic        AVS_WRITE_IN,
   input  wire logic [31:0] AVS_WRITEDATA_IN,
   input  wire logic [3:0]  AVS_BYTEENABLE_IN,
   output logic      [31:0] AVS_READDATA_OUT,
   output logic             AVS_WAITREQUEST_OUT,
   // Pump and programming voltage
   output logic             PUMP_ENABLE_OUT,
   output logic             PUMP_CLOCK_SELECT_OUT,
   output logic             OTP_VOLTAGE_OUT
);
   localparam int IW = $clog2(DEPTH);
   localparam int SECT = DEPTH / eppc_pkg::PROT_BITS;

   // ------------------------------------------------------------
   // Mode synchroniser and window counter
   // ------------------------------------------------------------
   logic [1:0] mode_s1_q, mode_s2_q;
   logic [6:0] win_cnt_q;
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         mode_s1_q <= 2'h_0;
         mode_s2_q <= 2'h_0;
         win_cnt_q <= 7'h_00;
      end else begin
         mode_s1_q <= MODE_IN;
         mode_s2_q <= mode_s1_q;
         if (win_cnt_q < 7'(PROT_WINDOW)) win_cnt_q <= win_cnt_q + 7'h_01;
      end
   end
   wire special_mode = (mode_s2_q == eppc_pkg::EPPC_MODE_BOOT)
                    || (mode_s2_q == eppc_pkg::EPPC_MODE_TEST);
   wire window_open  = (win_cnt_q < 7'(PROT_WINDOW)) || special_mode;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // Every access is answered in its second cycle; the first cycle only
   // registers the request so the array read path stays registered.
   logic ack_q;
   wire req       = (AVS_READ_IN || AVS_WRITE_IN) && !ack_q;
   wire wr_fire   = AVS_WRITE_IN && ack_q;
   wire rd_fire   = AVS_READ_IN && ack_q;
   wire lane0     = AVS_BYTEENABLE_IN[0];
   wire [7:0] wb  = AVS_WRITEDATA_IN[7:0];
   wire in_array  = AVS_ADDRESS_IN <= eppc_pkg::ARRAY_END_ADDR;
   wire [IW-1:0] arr_idx = AVS_ADDRESS_IN[IW+1:2];
   wire hit_pc    = AVS_ADDRESS_IN == eppc_pkg::PROG_CTRL_ADDR;
   wire hit_bp    = AVS_ADDRESS_IN == eppc_pkg::BLOCK_PROT_ADDR;
   wire hit_opt   = AVS_ADDRESS_IN == eppc_pkg::SYS_OPTION_ADDR;
   wire hit_setup = AVS_ADDRESS_IN == eppc_pkg::SETUP_REG_ADDR;
   wire hit_otp   = AVS_ADDRESS_IN == eppc_pkg::OTP_CTRL_ADDR;
   wire hit_stat  = AVS_ADDRESS_IN == eppc_pkg::STATUS_ADDR;

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   logic                     latch_q, pump_q, erase_q, pump_clock_select_q, otp_latch_q, otp_volt_q;
   logic [3:0]               prot_q;
   logic [7:0]               setup_q;
   logic [IW-1:0]            tgt_idx_q;
   logic                     tgt_setup_q;
   logic [7:0]               tgt_data_q;
   eppc_pkg::eppc_seq_t      seq_q, seq_d;

   function automatic logic [1:0] sect_of(input logic [IW-1:0] idx);
      sect_of = 2'(idx / IW'(SECT));
   endfunction

   wire pc_wr       = wr_fire && hit_pc && lane0;
   wire wr_latch    = wb[eppc_pkg::PC_LATCH_BIT];
   wire wr_pump     = wb[eppc_pkg::PC_PUMP_BIT];
   wire both_at_once = wr_latch && wr_pump && !latch_q;
   wire latch_d     = pc_wr ? (wr_latch && !both_at_once) : latch_q;
   wire pump_req    = wr_latch && wr_pump && (seq_q == eppc_pkg::EPPC_TARGET);
   wire tgt_prot    = tgt_setup_q ? (&prot_q) : prot_q[sect_of(tgt_idx_q)];
   wire array_vis   = setup_q[eppc_pkg::SETUP_VIS_BIT];
   wire tgt_wr      = wr_fire && lane0 && latch_q && (seq_q == eppc_pkg::EPPC_ARMED)
                   && ((in_array && array_vis) || hit_setup);
   wire pump_end    = pump_q && pc_wr && !wr_pump;
   wire do_commit   = pump_end && !tgt_prot;
   wire st_prog     = do_commit && !tgt_setup_q && !erase_q;
   wire st_erase    = do_commit && !tgt_setup_q && erase_q;

   always_comb begin
      seq_d = seq_q;
      unique case (seq_q)
         eppc_pkg::EPPC_IDLE:    if (latch_d) seq_d = eppc_pkg::EPPC_ARMED;
         eppc_pkg::EPPC_ARMED:   if (tgt_wr) seq_d = eppc_pkg::EPPC_TARGET;
         eppc_pkg::EPPC_TARGET:  if (pc_wr && pump_req) seq_d = eppc_pkg::EPPC_PUMPING;
         eppc_pkg::EPPC_PUMPING: if (pump_end) seq_d = eppc_pkg::EPPC_TARGET;
      endcase
      if (!latch_d) seq_d = eppc_pkg::EPPC_IDLE;
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ack_q <= 1'b0;
         seq_q <= eppc_pkg::EPPC_IDLE;
      end else begin
         ack_q <= req;
         seq_q <= seq_d;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         latch_q     <= 1'b0;
         pump_q      <= 1'b0;
         erase_q     <= 1'b0;
      end else begin
         latch_q <= latch_d;
         pump_q  <= latch_d && (pc_wr ? (wr_pump && pump_req) || (pump_q && wr_pump)
                                      : pump_q);
         if (pc_wr && !pump_q) erase_q <= wb[eppc_pkg::PC_ERASE_BIT];
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         prot_q      <= eppc_pkg::PROT_RESET;
         pump_clock_select_q      <= 1'b0;
         otp_latch_q <= 1'b0;
         otp_volt_q  <= 1'b0;
      end else begin
         if (wr_fire && hit_bp && lane0) begin
            // Ones always land; zeros only land while the window is open.
            prot_q <= window_open ? wb[3:0] : (prot_q | wb[3:0]);
         end
         if (wr_fire && hit_opt && lane0) pump_clock_select_q <= wb[eppc_pkg::OPT_PUMP_CLOCK_SELECT_BIT];
         if (wr_fire && hit_otp && lane0) begin
            otp_latch_q <= wb[eppc_pkg::OTP_LATCH_BIT];
            if (otp_latch_q) otp_volt_q <= wb[eppc_pkg::OTP_VOLT_BIT];
         end
      end
   end

   // The setup register is itself nonvolatile, so it resets to its erased state.
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         setup_q     <= eppc_pkg::SETUP_RESET;
         tgt_idx_q   <= '0;
         tgt_setup_q <= 1'b0;
         tgt_data_q  <= eppc_pkg::ERASED_BYTE;
      end else begin
         if (tgt_wr) begin
            tgt_idx_q   <= arr_idx;
            tgt_setup_q <= hit_setup;
            tgt_data_q  <= wb;
         end
         if (do_commit && tgt_setup_q) begin
            setup_q <= erase_q ? eppc_pkg::ERASED_BYTE : (setup_q & tgt_data_q);
         end
      end
   end

   // ------------------------------------------------------------
   // Array and read path
   // ------------------------------------------------------------
   logic [7:0] arr_rd;
   eppc_store #(
      .DEPTH    (DEPTH)
   ) u_store (
      .clk_in   (CLK_IN),
      .rst_n_in (RST_N_IN),
      .idx_in   (pump_q ? tgt_idx_q : arr_idx),
      .prog_in  (st_prog),
      .erase_in (st_erase),
      .data_in  (tgt_data_q),
      .data_out (arr_rd)
   );

   // While latched the array is not readable, matching a real cell in program.
   wire [7:0] arr_view = latch_q ? eppc_pkg::ERASED_BYTE : arr_rd;
   wire [7:0] stat_val = {5'h_00, win_cnt_q < 7'(PROT_WINDOW), special_mode, pump_q};
   wire [7:0] rd_byte  =
      (in_array && array_vis) ? arr_view :
      hit_pc    ? {5'h_00, erase_q, latch_q, pump_q} :
      hit_bp    ? {4'h_0, prot_q} :
      hit_opt   ? {1'b0, pump_clock_select_q, 6'h_00} :
      hit_setup ? setup_q :
      hit_otp   ? {2'h_0, otp_latch_q, 4'h_0, otp_volt_q} :
      hit_stat  ? stat_val : 8'h_00;

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         AVS_READDATA_OUT      <= 32'h_0000_0000;
         AVS_WAITREQUEST_OUT   <= 1'b1;
         PUMP_ENABLE_OUT       <= 1'b0;
         PUMP_CLOCK_SELECT_OUT <= 1'b0;
         OTP_VOLTAGE_OUT       <= 1'b0;
      end else begin
         AVS_READDATA_OUT      <= req && AVS_READ_IN ? {24'h_00_0000, rd_byte}
                                                   : AVS_READDATA_OUT;
         AVS_WAITREQUEST_OUT   <= !req;
         PUMP_ENABLE_OUT       <= pump_q && latch_d;
         PUMP_CLOCK_SELECT_OUT <= pump_clock_select_q;
         OTP_VOLTAGE_OUT       <= otp_volt_q;
      end
   end
   wire unused_ok = rd_fire;
endmodule : eppc_ctrl
`default_nettype wire

// ### sim/eppc_ctrl_checker.sv
// Concurrent checks on the bus handshake and the pump and voltage outputs.
// Assumes it is bound to eppc_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module eppc_ctrl_checker (
   // Watched ports
   input wire logic        CLK_IN,
   input wire logic        RST_N_IN,
   input wire logic [11:0] AVS_ADDRESS_IN,
   input wire logic        AVS_READ_IN,
   input wire logic        AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   input wire logic [3:0]  AVS_BYTEENABLE_IN,
   input wire logic        AVS_WAITREQUEST_OUT,
   input wire logic        PUMP_ENABLE_OUT,
   input wire logic        PUMP_CLOCK_SELECT_OUT,
   input wire logic        OTP_VOLTAGE_OUT
);
   // A write lands at the edge where waitrequest is low, so the mirrors follow that edge.
   logic       acc, pc_wr, opt_wr, otp_wr, otp_arm, lat_q, tgt_q, olat_q;
   logic [7:0] wd;
   assign acc     = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_BYTEENABLE_IN[0];
   assign wd      = AVS_WRITEDATA_IN[7:0];
   assign pc_wr   = acc && AVS_ADDRESS_IN == eppc_pkg::PROG_CTRL_ADDR;
   assign opt_wr  = acc && AVS_ADDRESS_IN == eppc_pkg::SYS_OPTION_ADDR;
   assign otp_wr  = acc && AVS_ADDRESS_IN == eppc_pkg::OTP_CTRL_ADDR;
   assign otp_arm = otp_wr && wd[0] && olat_q;
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         {lat_q, tgt_q, olat_q} <= 3'b000;
      end else begin
         if (pc_wr) lat_q <= wd[1] && !(wd[0] && !lat_q);
         if (pc_wr && !wd[1]) tgt_q <= 1'b0;
         else if (acc && lat_q && (AVS_ADDRESS_IN <= eppc_pkg::ARRAY_END_ADDR ||
                  AVS_ADDRESS_IN == eppc_pkg::SETUP_REG_ADDR)) tgt_q <= 1'b1;
         if (otp_wr) olat_q <= wd[5];
      end
   end
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   sequence s_arm_req;
      pc_wr && wd[1:0] == 2'b11;
   endsequence
   a_wait_answer: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
      |=> !AVS_WAITREQUEST_OUT) else $error("request not answered next cycle");
   a_wait_pulse: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
      else $error("waitrequest low for more than one cycle");
   // The pump output rises two flops behind the landing write, so the set checks look two edges on; a clearing write drops it one edge on.
   a_single_arm: assert property (s_arm_req ##0 !lat_q |-> ##2 !PUMP_ENABLE_OUT)
      else $error("pump set by one combined write");
   a_pump_on: assert property (s_arm_req ##0 (lat_q && tgt_q) |-> ##2 PUMP_ENABLE_OUT)
      else $error("pump not applied after full sequence");
   a_pump_order: assert property ($rose(PUMP_ENABLE_OUT) |-> $past(tgt_q))
      else $error("pump applied without target write");
   a_pump_drop: assert property (pc_wr && !wd[1] |=> !PUMP_ENABLE_OUT)
      else $error("pump left on with latch clear");
   a_pump_clock_select_load: assert property (opt_wr |-> ##2 PUMP_CLOCK_SELECT_OUT == $past(wd[6], 2))
      else $error("pump clock select not loaded");
   a_pump_clock_select_hold: assert property (!opt_wr |-> ##2 $stable(PUMP_CLOCK_SELECT_OUT))
      else $error("pump clock select changed unasked");
   a_otp_gate: assert property ($rose(OTP_VOLTAGE_OUT) |-> $past(otp_arm, 2))
      else $error("otp voltage set without latch");
   a_otp_hold: assert property (!otp_wr |-> ##2 $stable(OTP_VOLTAGE_OUT))
      else $error("otp voltage changed unasked");
endmodule : eppc_ctrl_checker
bind eppc_ctrl eppc_ctrl_checker u_eppc_ctrl_checker (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
   .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
   .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
   .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .PUMP_ENABLE_OUT(PUMP_ENABLE_OUT),
   .PUMP_CLOCK_SELECT_OUT(PUMP_CLOCK_SELECT_OUT), .OTP_VOLTAGE_OUT(OTP_VOLTAGE_OUT));
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the program and protect controller.
// Assumes a shortened protect window of 8 cycles; a model holds array and protect state.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [11:0] PC = eppc_pkg::PROG_CTRL_ADDR;
   localparam logic [11:0] BP = eppc_pkg::BLOCK_PROT_ADDR;
   localparam logic [11:0] SU = eppc_pkg::SETUP_REG_ADDR;
   localparam logic [11:0] OT = eppc_pkg::OTP_CTRL_ADDR;
   logic        clk = 0, rst_n = 0, rd = 0, wr = 0, waitreq, pump, pump_clock_select, otp;
   logic [1:0]  mode = 0;
   logic [11:0] addr = 0;
   logic [31:0] wdata = 0, rdata, r;
   logic [3:0]  be = 4'hF;
   int          failures = 0, total_checks = 0, i, a, mem[512], prot, setup;
   eppc_ctrl #(.PROT_WINDOW(8)) u_eppc_ctrl (.CLK_IN(clk), .RST_N_IN(rst_n), .MODE_IN(mode),
      .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
      .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
      .PUMP_ENABLE_OUT(pump), .PUMP_CLOCK_SELECT_OUT(pump_clock_select), .OTP_VOLTAGE_OUT(otp));
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic end_sim;
      if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input int exp);
      total_checks++;
      if (got !== 32'(exp)) begin
         failures++;
         $display("CHECK FAILED t=%0t got %h expected %h", $time, got, 32'(exp));
      end
   endtask : chk
   // The request is held until waitrequest is seen low; a hang ends at the bound.
   task automatic bus(input logic w, input logic [11:0] ad, input logic [7:0] dt);
      int k;
      k = 0;
      @(posedge clk);
      {addr, wdata, wr, rd} <= {ad, 24'h0, dt, w, !w};
      do begin
         @(posedge clk);
         k++;
      end while (waitreq !== 1'b0 && k < 50);
      if (k >= 50) failures++;
      r = rdata;
      {wr, rd} <= 2'b00;
   endtask : bus
   task automatic rchk(input logic [11:0] ad, input int exp);
      bus(0, ad, 8'h00);
      chk(r, exp);
   endtask : rchk
   function automatic int ex(input int idx);
      return setup[0] ? mem[idx] : 0;
   endfunction : ex
   task automatic prog(input logic [11:0] ad, input logic [7:0] dt, input logic er);
      bus(1, PC, {5'h0, er, 2'b10});
      bus(1, ad, dt);
      bus(1, PC, {5'h0, er, 2'b11});
      bus(1, PC, {5'h0, er, 2'b10});
      bus(1, PC, 8'h00);
      if (ad == SU) begin
         if (prot != 15) setup = er ? 255 : setup & dt;
      end else if (!prot[ad[10:9]]) mem[ad[10:2]] = er ? 255 : mem[ad[10:2]] & dt;
   endtask : prog
   task automatic restart(input logic [1:0] m);
      rst_n <= 0;
      mode <= m;
      repeat (10) @(posedge clk);
      rst_n <= 1;
      foreach (mem[k]) mem[k] = 255;
      {prot, setup} = {32'd15, 32'd255};
   endtask : restart
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      end_sim();
   end
   initial begin
      void'($urandom(32'haf87e15c));
      restart(2'd0);
      rchk(BP, prot);
      bus(1, BP, 8'h00);
      prot = 0;
      rchk(BP, prot);
      for (i = 0; i < 8; i++) begin
         a = (i % 4) * 128 + $urandom_range(127);
         rchk(12'(a * 4), ex(a));
         prog(12'(a * 4), 8'($urandom), i == 6);
         rchk(12'(a * 4), ex(a));
         prog(12'(a * 4), 8'($urandom), 0);
         rchk(12'(a * 4), ex(a));
      end
      bus(1, PC, 8'h03);
      rchk(PC, 0);
      chk(pump, 0);
      bus(1, 12'(a * 4), 8'h00);
      rchk(12'(a * 4), ex(a));
      bus(1, 12'hFF0, 8'h5A);
      rchk(12'hFF0, 0);
      rchk(12'h7FC, ex(511));
      bus(1, BP, 8'h0F);
      prot = 15;
      rchk(BP, prot);
      bus(1, BP, 8'h00);
      rchk(BP, prot);
      prog(12'(a * 4), 8'h00, 0);
      rchk(12'(a * 4), ex(a));
      prog(SU, 8'h00, 0);
      rchk(SU, setup);
      for (i = 0; i < 2; i++) begin
         bus(1, eppc_pkg::SYS_OPTION_ADDR, 8'(i << 6));
         repeat (2) @(negedge clk);
         chk(pump_clock_select, i);
      end
      bus(1, OT, 8'h01);
      repeat (2) @(negedge clk);
      chk(otp, 0);
      bus(1, OT, 8'h20);
      bus(1, OT, 8'h21);
      repeat (2) @(negedge clk);
      chk(otp, 1);
      rchk(OT, 8'h21);
      for (i = 2; i < 4; i++) begin
         restart(2'(i));
         repeat (20) @(posedge clk);
         bus(1, BP, 8'h00);
         bus(1, BP, 8'h0F);
         bus(1, BP, 8'h00);
         prot = 0;
         rchk(BP, prot);
      end
      prog(SU, 8'hFE, 0);
      rchk(SU, setup);
      rchk(12'(a * 4), ex(a));
      prog(SU, 8'h00, 1);
      rchk(12'(a * 4), ex(a));
      end_sim();
   end
endmodule : testbench
`default_nettype wire
